/* hdl/lcf_ctrl.sv */
// lcf_ctrl: control mode strap, hardware pin configuration, parallel register
// port and the merged interrupt request of the line interface
// assumes: all pins are asynchronous; channel events are one-cycle pulses on clk_sys
// How it works
// - strap 00 hw, 01 serial, 10/11 parallel styles
// - hw edge pin picks receive launch edge
// - format pins: hdb3, ami, dual rail, slicer
// - inband loopback only under software control
// - any unmasked pending source raises request
// - global mask bit silences interrupt output
// - two mask registers mask sources individually
// - summary and two source status registers
// - interrupt driver open drain or push-pull
`timescale 1ns/100ps
`include "lcf_consts.svh"
module lcf_ctrl (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // mode strap and hardware config pins
    input wire logic [1:0] modeSel,
    input wire logic rxClockEdgeSelect,
    input wire logic lineFormatSelectHi,
    input wire logic lineFormatSelectLo,
    input wire logic ch1LoopSelectHi,
    input wire logic ch1LoopSelectLo,
    // parallel register port
    input wire logic csN,
    input wire logic strobeN,
    input wire logic dirOrWrN,
    input wire logic [5:0] addr,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    // interrupt sources from the channels
    input wire logic [7:0] ch1Event,
    input wire logic [7:0] ch2Event,
    // decoded configuration
    output lcf_pkg::lcf_mode_t ctrlMode,
    output logic rxLaunchFalling,
    output logic singleRail,
    output logic amiCoding,
    output logic cdrEnable,
    output logic slicerMode,
    output lcf_pkg::lcf_loop_t ch1Loop,
    output logic inbandLoopAllowed,
    // interrupt pin
    output logic irqOut,
    output logic irqOe
);
    import lcf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation
    logic [23:0] syncBus;
    logic [1:0] modeS;
    logic edgeS, fmtHiS, fmtLoS, loopHiS, loopLoS, csS, strobeS, dirS;
    logic [5:0] addrS;
    logic [7:0] dataS;

    lcf_sync #(.WIDTH(24)) u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .pinIn({modeSel, rxClockEdgeSelect, lineFormatSelectHi, lineFormatSelectLo,
                ch1LoopSelectHi, ch1LoopSelectLo, csN, strobeN, dirOrWrN, addr, dataIn}),
        .syncOut(syncBus)
    );
    // reset values of the flops read as cs low and strobes active, not idle,
    // so any access is gated by capDone, since cs reads zero for two cycles after release
    assign {modeS, edgeS, fmtHiS, fmtLoS, loopHiS, loopLoS, csS, strobeS, dirS,
            addrS, dataS} = syncBus;

    ////////////////////////////////////////////////////////////////////////
    // strap capture after reset release
    logic [1:0] capCnt, next_capCnt;
    lcf_mode_t next_ctrlMode;
    logic capDone;

    always_comb begin
        next_capCnt = capCnt;
        next_ctrlMode = ctrlMode;
        if (capCnt != `LCF_CAP_DONE) begin
            next_capCnt = capCnt + 2'h1;
        end
        if (capCnt == `LCF_CAP_LAST) begin
            next_ctrlMode = lcf_mode_t'(modeS);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            capCnt <= 2'h0;
            ctrlMode <= LCF_MODE_HW;
        end else begin
            capCnt <= next_capCnt;
            ctrlMode <= next_ctrlMode;
        end
    end

    assign capDone = (capCnt == `LCF_CAP_DONE);

    ////////////////////////////////////////////////////////////////////////
    // hardware pin decode; held at defaults under software control
    logic hwMode, parMode;
    logic [1:0] fmtSel;

    assign hwMode = capDone && (ctrlMode == LCF_MODE_HW);
    // serial frames are handled elsewhere; this port only serves parallel modes
    assign parMode = capDone && (ctrlMode == LCF_MODE_PAR_DS || ctrlMode == LCF_MODE_PAR_RDWR);
    assign fmtSel = {fmtHiS, fmtLoS};

    logic next_rxLaunchFalling, next_singleRail, next_amiCoding, next_cdrEnable;
    logic next_slicerMode, next_inband;
    lcf_loop_t next_ch1Loop;

    always_comb begin
        next_rxLaunchFalling = 1'b0;
        next_singleRail = 1'b1;
        next_amiCoding = 1'b0;
        next_cdrEnable = 1'b1;
        next_slicerMode = 1'b0;
        next_ch1Loop = LCF_LOOP_NONE;
        next_inband = capDone && (ctrlMode != LCF_MODE_HW);
        if (hwMode) begin
            next_rxLaunchFalling = edgeS;
            case (fmtSel)
                2'b00: begin
                    next_singleRail = 1'b1;
                end
                2'b01: begin
                    next_amiCoding = 1'b1;
                end
                2'b10: begin
                    next_singleRail = 1'b0;
                end
                2'b11: begin
                    next_singleRail = 1'b0;
                    next_cdrEnable = 1'b0;
                    next_slicerMode = 1'b1;
                end
                default: begin
                    next_singleRail = 1'b1;
                end
            endcase
            next_ch1Loop = lcf_loop_t'({loopHiS, loopLoS});
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rxLaunchFalling <= 1'b0;
            singleRail <= 1'b1;
            amiCoding <= 1'b0;
            cdrEnable <= 1'b1;
            slicerMode <= 1'b0;
            ch1Loop <= LCF_LOOP_NONE;
            inbandLoopAllowed <= 1'b0;
        end else begin
            rxLaunchFalling <= next_rxLaunchFalling;
            singleRail <= next_singleRail;
            amiCoding <= next_amiCoding;
            cdrEnable <= next_cdrEnable;
            slicerMode <= next_slicerMode;
            ch1Loop <= next_ch1Loop;
            inbandLoopAllowed <= next_inband;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // parallel register port and interrupt registers
    logic rdAct, wrAct, rdPrev, wrPrev, rdStart, wrStart;
    logic [7:0] maskA, maskB, statusA, statusB, globalReg, summary, readMux;
    logic [7:0] next_maskA, next_maskB, next_statusA, next_statusB, next_globalReg;
    logic [7:0] next_dataOut;
    logic [7:0] clrA, clrB;

    // strobe style picks between data strobe with direction and split strobes
    always_comb begin
        rdAct = 1'b0;
        wrAct = 1'b0;
        if (parMode && !csS) begin
            if (ctrlMode == LCF_MODE_PAR_RDWR) begin
                rdAct = !strobeS;
                wrAct = !dirS;
            end else begin
                rdAct = !strobeS && dirS;
                wrAct = !strobeS && !dirS;
            end
        end
    end

    assign rdStart = rdAct && !rdPrev;
    assign wrStart = wrAct && !wrPrev;
    assign summary = {6'h00, |(statusB & ~maskB), |(statusA & ~maskA)};

    always_comb begin
        case (addrS)
            `LCF_OFS_IRQ_MASK_FIRST: readMux = maskA;
            `LCF_OFS_IRQ_MASK_SECOND: readMux = maskB;
            `LCF_OFS_IRQ_STATUS_FIRST: readMux = statusA;
            `LCF_OFS_IRQ_STATUS_SECOND: readMux = statusB;
            `LCF_OFS_GLOBAL_IRQ_MASK: readMux = globalReg;
            `LCF_OFS_IRQ_CHANNEL_SUMMARY: readMux = summary;
            default: readMux = 8'h00;
        endcase
    end

    always_comb begin
        next_maskA = maskA;
        next_maskB = maskB;
        next_globalReg = globalReg;
        next_dataOut = dataOut;
        clrA = 8'h00;
        clrB = 8'h00;
        if (wrStart) begin
            case (addrS)
                `LCF_OFS_IRQ_MASK_FIRST: next_maskA = dataS;
                `LCF_OFS_IRQ_MASK_SECOND: next_maskB = dataS;
                `LCF_OFS_GLOBAL_IRQ_MASK: next_globalReg = {5'h00, dataS[2:0]};
                default: next_globalReg = globalReg;
            endcase
        end
        if (rdStart) begin
            // snapshot taken before the clear, so a read never loses a bit
            next_dataOut = readMux;
            clrA = (addrS == `LCF_OFS_IRQ_STATUS_FIRST) ? statusA : 8'h00;
            clrB = (addrS == `LCF_OFS_IRQ_STATUS_SECOND) ? statusB : 8'h00;
        end
        // a new event beats a clear in the same cycle
        next_statusA = (statusA & ~clrA) | ch1Event;
        next_statusB = (statusB & ~clrB) | ch2Event;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdPrev <= 1'b0;
            wrPrev <= 1'b0;
            maskA <= `LCF_RST_IRQ_MASK;
            maskB <= `LCF_RST_IRQ_MASK;
            statusA <= 8'h00;
            statusB <= 8'h00;
            globalReg <= `LCF_RST_GLOBAL;
            dataOut <= `LCF_RST_DATA;
            dataOe <= 1'b0;
        end else begin
            rdPrev <= rdAct;
            wrPrev <= wrAct;
            maskA <= next_maskA;
            maskB <= next_maskB;
            statusA <= next_statusA;
            statusB <= next_statusB;
            globalReg <= next_globalReg;
            dataOut <= next_dataOut;
            dataOe <= rdAct;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // merged interrupt request and pin driver
    logic irqReq;
    lcf_drive_t drive;

    assign drive = lcf_drive_t'(globalReg[`LCF_DRIVE_HI_BIT:`LCF_DRIVE_LO_BIT]);
    // no interrupt in hardware mode: masks are software state
    assign irqReq = !hwMode && capDone && !globalReg[`LCF_GLOBAL_MASK_BIT]
                    && (summary[0] || summary[1]);

    always_comb begin
        case (drive)
            LCF_DRV_PP_LOW: begin
                irqOut = !irqReq;
                irqOe = 1'b1;
            end
            LCF_DRV_PP_HIGH: begin
                irqOut = irqReq;
                irqOe = 1'b1;
            end
            default: begin
                irqOut = 1'b0;
                irqOe = irqReq;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    strapCapture_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (capCnt == `LCF_CAP_LAST) |=> (ctrlMode == $past(modeS)))
        else $error("strap not captured");
    rxEdge_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        hwMode ##1 hwMode |-> (rxLaunchFalling == $past(edgeS)))
        else $error("receive edge mismatch");
    edgeLevel_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (hwMode && !edgeS) |=> !rxLaunchFalling)
        else $error("low level must pick rising edge");
    slicerFmt_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (hwMode && fmtSel == 2'b11) |=> (slicerMode && !cdrEnable && !singleRail))
        else $error("slicer format wrong");
    amiFmt_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (hwMode && fmtSel == 2'b01) |=> (amiCoding && singleRail))
        else $error("ami format wrong");
    csIgnore_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        csS |=> (!dataOe && $stable(maskA) && $stable(globalReg)))
        else $error("port acted with chip select high");
    remoteLoop_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (hwMode && loopHiS && loopLoS) |=> (ch1Loop == LCF_LOOP_REMOTE))
        else $error("loop decode wrong");
    noInband_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        $past(hwMode) |-> !inbandLoopAllowed)
        else $error("inband allowed in hardware mode");
    irqRaise_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (parMode && ch1Event[0] && !maskA[0] && !next_globalReg[0]) |=> irqReq)
        else $error("unmasked event did not raise request");
    globalMask_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        globalReg[`LCF_GLOBAL_MASK_BIT] |-> (!irqReq && !(irqOe && irqOut == (drive
            == LCF_DRV_PP_HIGH))))
        else $error("request passed global mask");
    allMasked_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (maskA == 8'hFF && maskB == 8'hFF) |-> !irqReq)
        else $error("masked sources raised request");
    statusSticky_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        ch2Event[3] |=> statusB[3] && summary[1] == !maskB[3] || (|(statusB & ~maskB)))
        else $error("status not set");
    pushLow_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (drive == LCF_DRV_PP_LOW) |-> (irqOe && irqOut == !irqReq))
        else $error("push-pull low drive wrong");

    writeSeen_c: cover property (@(posedge clk_sys) disable iff (!nrst) wrStart);
    readClear_c: cover property (@(posedge clk_sys) disable iff (!nrst)
        rdStart && addrS == `LCF_OFS_IRQ_STATUS_FIRST && statusA != 8'h00);
    irqFire_c: cover property (@(posedge clk_sys) disable iff (!nrst) irqReq);
    hwSlicer_c: cover property (@(posedge clk_sys) disable iff (!nrst) slicerMode);
endmodule : lcf_ctrl

/* hdl/lcf_consts.svh */
// lcf_consts.svh: register offsets, field positions, reset values and counts
// assumes: included by its bare name from lcf_ctrl
`ifndef LCF_CONSTS_SVH
`define LCF_CONSTS_SVH

// register offsets on the 6-bit parallel address
`define LCF_OFS_IRQ_MASK_FIRST 6'h13
`define LCF_OFS_IRQ_MASK_SECOND 6'h14
`define LCF_OFS_IRQ_STATUS_FIRST 6'h18
`define LCF_OFS_IRQ_STATUS_SECOND 6'h19
`define LCF_OFS_GLOBAL_IRQ_MASK 6'h20
`define LCF_OFS_IRQ_CHANNEL_SUMMARY 6'h21

// fields of global_irq_mask
`define LCF_GLOBAL_MASK_BIT 0
`define LCF_DRIVE_LO_BIT 1
`define LCF_DRIVE_HI_BIT 2

// reset values
`define LCF_RST_IRQ_MASK 8'hFF
`define LCF_RST_GLOBAL 8'h01
`define LCF_RST_DATA 8'h00

// strap capture: synchroniser depth plus one settle cycle
`define LCF_CAP_LAST 2'h2
`define LCF_CAP_DONE 2'h3

`endif

/* hdl/lcf_pkg.sv */
// lcf_pkg: types of the control mode and hardware configuration block
// assumes: lcf_consts.svh is on the include path
package lcf_pkg;
    typedef enum logic [1:0] {
        LCF_MODE_HW = 2'b00,
        LCF_MODE_SERIAL = 2'b01,
        LCF_MODE_PAR_DS = 2'b10,
        LCF_MODE_PAR_RDWR = 2'b11
    } lcf_mode_t;

    typedef enum logic [1:0] {
        LCF_LOOP_NONE = 2'b00,
        LCF_LOOP_ANALOG = 2'b01,
        LCF_LOOP_DIGITAL = 2'b10,
        LCF_LOOP_REMOTE = 2'b11
    } lcf_loop_t;

    typedef enum logic [1:0] {
        LCF_DRV_OPEN_DRAIN = 2'b00,
        LCF_DRV_PP_LOW = 2'b01,
        LCF_DRV_PP_HIGH = 2'b10,
        LCF_DRV_RSVD = 2'b11
    } lcf_drive_t;
endpackage : lcf_pkg

/* hdl/lcf_sync.sv */
// lcf_sync: two-flop synchroniser for a bundle of pin levels
// assumes: each bit is an independent slow level; no bus coherency implied
`timescale 1ns/100ps
module lcf_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // levels
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;

    initial begin
        if (WIDTH < 1) begin
            $error("lcf_sync: WIDTH must be at least 1");
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stage1 <= '0;
            syncOut <= '0;
        end else begin
            stage1 <= pinIn;
            syncOut <= stage1;
        end
    end
endmodule : lcf_sync

/* tb/lcf_host_model.sv */
// lcf_host_model: host microcontroller on the parallel register port
// assumes: strap picks a parallel style; the bench calls access() in turn
`timescale 1ns/100ps
module lcf_host_model (
    // clock and style
    input wire logic clk_sys,
    input wire logic rdWrStyle,
    // port pins
    output logic csN,
    output logic strobeN,
    output logic dirOrWrN,
    output logic [5:0] addr,
    output logic [7:0] dataIn,
    input wire logic [7:0] dataOut,
    input wire logic dataOe
);
    initial begin
        csN = 1'b1;
        strobeN = 1'b1;
        dirOrWrN = 1'b1;
        addr = 6'h00;
        dataIn = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one access; ok stays low if a read gets no answer in time
    task automatic access(input logic wr, input logic sel, input logic [5:0] a,
            input logic [7:0] d, output logic [7:0] q, output logic ok);
        int n;
        q = 8'h00;
        ok = 1'b0;
        n = 0;
        @(posedge clk_sys);
        addr <= a;
        dataIn <= d;
        dirOrWrN <= rdWrStyle | !wr;
        repeat (3) @(posedge clk_sys);
        csN <= !sel;
        if (wr && rdWrStyle) begin
            dirOrWrN <= 1'b0;
        end else begin
            strobeN <= 1'b0;
        end
        if (!wr && sel) begin
            // look at the falling edge, where the registered answer has settled
            while (!ok && n < 8) begin
                @(negedge clk_sys);
                n++;
                ok = (dataOe === 1'b1);
            end
            q = dataOut;
            @(posedge clk_sys);
        end else begin
            repeat (4) @(posedge clk_sys);
            ok = 1'b1;
        end
        csN <= 1'b1;
        strobeN <= 1'b1;
        dirOrWrN <= 1'b1;
        // released lines must not keep a stale value
        addr <= ~a;
        dataIn <= ~d;
        repeat (5) @(posedge clk_sys);
    endtask : access
endmodule : lcf_host_model

/* tb/lcf_ctrl_tb_top.sv */
// lcf_ctrl_tb_top: self-checking bench for the control mode block
// assumes: lcf_pkg, lcf_ctrl and lcf_host_model are compiled first
`timescale 1ns/100ps
module lcf_ctrl_tb_top;
    logic clk_sys, nrst, rdWrStyle;
    logic [1:0] modeSel;
    logic [4:0] pins;
    logic [7:0] ch1Ev, ch2Ev, dataIn, dataOut, cfgSeen, irqSeen;
    logic [5:0] addr;
    logic csN, strobeN, dirOrWrN, dataOe, irqOut, irqOe;
    logic rxLaunchFalling, singleRail, amiCoding, cdrEnable, slicerMode, inbandLoopAllowed;
    lcf_pkg::lcf_mode_t ctrlMode;
    lcf_pkg::lcf_loop_t ch1Loop;
    int bad_count;
    int n_tests;
    // pins {edge, format hi/lo, loop hi/lo} beside the expected cfgSeen
    logic [12:0] hwRows [4] = '{{5'b00000, 8'h50}, {5'b10101, 8'hF2}, {5'b01010, 8'h14},
        {5'b11111, 8'h8E}};

    assign cfgSeen = {rxLaunchFalling, singleRail, amiCoding, cdrEnable, slicerMode, ch1Loop,
        inbandLoopAllowed};
    assign irqSeen = {6'h00, irqOe, irqOut};

    lcf_ctrl DUT (.clk_sys(clk_sys), .nrst(nrst), .modeSel(modeSel),
        .rxClockEdgeSelect(pins[4]), .lineFormatSelectHi(pins[3]), .lineFormatSelectLo(pins[2]),
        .ch1LoopSelectHi(pins[1]), .ch1LoopSelectLo(pins[0]), .csN(csN), .strobeN(strobeN),
        .dirOrWrN(dirOrWrN), .addr(addr), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
        .ch1Event(ch1Ev), .ch2Event(ch2Ev), .ctrlMode(ctrlMode),
        .rxLaunchFalling(rxLaunchFalling), .singleRail(singleRail), .amiCoding(amiCoding),
        .cdrEnable(cdrEnable), .slicerMode(slicerMode), .ch1Loop(ch1Loop),
        .inbandLoopAllowed(inbandLoopAllowed), .irqOut(irqOut), .irqOe(irqOe));

    lcf_host_model host (.clk_sys(clk_sys), .rdWrStyle(rdWrStyle), .csN(csN),
        .strobeN(strobeN), .dirOrWrN(dirOrWrN), .addr(addr), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe));

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (bad_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [7:0] seen, input logic [7:0] want, input string msg);
        n_tests++;
        if (seen !== want) begin
            bad_count++;
            $display("unexpected at %0t: %s seen %h want %h", $time, msg, seen, want);
        end
    endtask : check

    task automatic rdchk(input logic [5:0] a, input logic [7:0] want, input string msg);
        logic [7:0] q;
        logic ok;
        host.access(1'b0, 1'b1, a, 8'h00, q, ok);
        if (ok !== 1'b1) begin
            bad_count++;
            end_sim();
        end else begin
            check(q, want, msg);
        end
    endtask : rdchk

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic ok;
        host.access(1'b1, 1'b1, a, d, q, ok);
    endtask : wr

    task automatic pulse(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk_sys);
        ch1Ev <= a;
        ch2Ev <= b;
        @(posedge clk_sys);
        ch1Ev <= 8'h00;
        ch2Ev <= 8'h00;
        repeat (2) @(posedge clk_sys);
    endtask : pulse

    task automatic do_reset(input logic [1:0] m);
        @(posedge clk_sys);
        nrst <= 1'b0;
        modeSel <= m;
        rdWrStyle <= m[0];
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        // strap is captured a few edges after release
        repeat (6) @(posedge clk_sys);
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (50000) @(posedge clk_sys);
        bad_count++;
        end_sim();
    end

    initial begin
        logic [7:0] q;
        logic ok;
        bad_count = 0;
        n_tests = 0;
        nrst = 1'b0;
        modeSel = 2'b00;
        rdWrStyle = 1'b0;
        pins = 5'b00000;
        ch1Ev = 8'h00;
        ch2Ev = 8'h00;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (6) @(posedge clk_sys);
        pulse(8'hFF, 8'hFF);
        check(irqSeen, 8'h00, "irq pin in hw mode");
        for (int i = 0; i < 4; i++) begin
            pins <= hwRows[i][12:8];
            repeat (5) @(posedge clk_sys);
            check(cfgSeen, hwRows[i][7:0], "hw config");
        end
        for (int m = 0; m < 4; m++) begin
            do_reset(m[1:0]);
            check({6'h00, ctrlMode}, m[7:0], "mode");
            check(cfgSeen, (m == 0) ? 8'h8E : 8'h51, "config by mode");
        end
        wr(6'h13, 8'h5A);
        rdchk(6'h13, 8'h5A, "rd/wr style access");
        do_reset(2'b10);
        rdchk(6'h13, 8'hFF, "mask1 reset");
        rdchk(6'h14, 8'hFF, "mask2 reset");
        rdchk(6'h20, 8'h01, "global reset");
        rdchk(6'h3F, 8'h00, "unmapped read");
        wr(6'h13, 8'hFE);
        wr(6'h14, 8'hF7);
        wr(6'h20, 8'h04);
        check(irqSeen, 8'h02, "idle active high");
        pulse(8'h01, 8'h00);
        check(irqSeen, 8'h03, "unmasked source");
        rdchk(6'h21, 8'h01, "summary ch1");
        rdchk(6'h18, 8'h01, "status1");
        rdchk(6'h18, 8'h00, "status1 cleared");
        check(irqSeen, 8'h02, "irq after clear");
        pulse(8'h02, 8'h00);
        check(irqSeen, 8'h02, "masked source");
        rdchk(6'h18, 8'h02, "masked status");
        pulse(8'h00, 8'h08);
        check(irqSeen, 8'h03, "ch2 source");
        rdchk(6'h21, 8'h02, "summary ch2");
        wr(6'h20, 8'h05);
        check(irqSeen, 8'h02, "global mask");
        wr(6'h20, 8'h02);
        check(irqSeen, 8'h02, "active low asserted");
        rdchk(6'h19, 8'h08, "status2");
        check(irqSeen, 8'h03, "active low idle");
        wr(6'h20, 8'h00);
        pulse(8'h00, 8'h08);
        check(irqSeen, 8'h02, "open drain asserted");
        rdchk(6'h19, 8'h08, "status2 again");
        check(irqSeen, 8'h00, "open drain released");
        host.access(1'b1, 1'b0, 6'h13, 8'h00, q, ok);
        rdchk(6'h13, 8'hFE, "write without select");
        end_sim();
    end
endmodule : lcf_ctrl_tb_top
